// [aisc_pkg.sv]
// Purpose: constants for the analog input scaling curve unit
// Assumes: values are signed fixed point with FRAC_BITS fraction bits
// Notes: register map sits on an APB slave, one word per register
// Operation
// (R1) with filtering on, the curve input is a running average, not the raw sample
// (R2) software sets the time constant at least twice the disturbance period
// (R3) out-of-range is raised when the input is below minimum or above maximum
// (R4) the out-of-range flag is a plain output usable by logic and relays
// (R5) a lost input signal freezes the curve input at its last valid value
// (R6) input refreshes once per update cycle, set in 5 ms steps, default 150 ms
// (R7) output formatting: 0 float, 1 floor, 2 ceiling, 3 nearest integer
// (R8) default mapping is a line through two points, inputs up to 4000; the code resets point 2 to input 0x100 with both outputs 0
// (R9) points 3 to 20 can each be marked used, up to 20 points
// (R10) the out-of-range flag stays low unless out-of-range signalling is enabled
// (R11) a source code 0 to 41 picks the measurement feeding the curve
// (R12) output is linear interpolation between the two active points around the input
// (R13) the filter is a first-order recursion run once per update cycle
`default_nettype none
package aisc_pkg;
  localparam int CLK_PERIOD_NS = 100;
  localparam int STEP_TIME_NS = 5_000_000;
  localparam int STEP_CYC = (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FRAC_BITS = 8;
  localparam int NPTS = 20;
  localparam logic [31:0] FRAC_MASK = 32'h0000_00FF;
  localparam logic [31:0] FRAC_HALF = 32'h0000_0080;
  localparam logic [15:0] CYCLE_RST = 16'h001E;
  localparam logic [15:0] TC_RST = 16'h00C8;
  localparam logic [5:0] SRC_MAX = 6'h29;
  localparam logic [31:0] PT2_X_RST = 32'h0000_0100;
  localparam logic [1:0] RND_FLOAT = 2'h0;
  localparam logic [1:0] RND_FLOOR = 2'h1;
  localparam logic [1:0] RND_CEIL = 2'h2;
  localparam logic [1:0] RND_NEAR = 2'h3;
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_SRC = 12'h004;
  localparam logic [11:0] OFS_CYCLE = 12'h008;
  localparam logic [11:0] OFS_TC = 12'h00C;
  localparam logic [11:0] OFS_MIN = 12'h010;
  localparam logic [11:0] OFS_MAX = 12'h014;
  localparam logic [11:0] OFS_INPUT = 12'h018;
  localparam logic [11:0] OFS_OUTPUT = 12'h01C;
  localparam logic [11:0] OFS_STATUS = 12'h020;
  localparam logic [11:0] OFS_CLEAR = 12'h024;
  localparam logic [11:0] OFS_IRQ_EN = 12'h028;
  localparam logic [11:0] OFS_PT_USE = 12'h02C;
  localparam logic [11:0] OFS_PT_BASE = 12'h040;
  localparam logic [11:0] OFS_PT_END = 12'h0E0;
  localparam int CTRL_EN = 0;
  localparam int CTRL_FILT = 1;
  localparam int CTRL_OOR = 2;
  localparam int CTRL_RND = 4;
  localparam int EV_OOR = 0;
  localparam int EV_LOST = 1;
  localparam int EV_DONE = 2;
  localparam int DIV_STEPS = 64;
  typedef enum {ST_IDLE, ST_SCAN, ST_DIV, ST_OUT} aisc_state_t;
endpackage : aisc_pkg
`default_nettype wire

// [aisc_curve.sv]
// Purpose: one scaling curve channel: select, filter, limit check, map, round
// Assumes: front end answers meas_sel with meas_value (Q.8) and meas_valid in the same cycle
// Notes: curve points are expected in ascending input order
`timescale 1ns/1ps
`default_nettype none
module aisc_curve
  import aisc_pkg::*;
#(
  parameter int STEP_CYCLES = STEP_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [5:0] meas_sel,
  input wire logic signed [31:0] meas_value,
  input wire logic meas_valid,
  output logic signed [31:0] curve_value,
  output logic curve_value_valid,
  output logic curve_out_of_range_flag,
  output logic irq
);
  logic ctrl_en, filt_en, oor_en;
  logic [1:0] rnd_mode;
  logic [5:0] src_sel;
  logic [15:0] cycle_steps, tc_steps;
  logic signed [31:0] in_min, in_max, cur_in, filt;
  logic signed [31:0] pt_x [NPTS];
  logic signed [31:0] pt_y [NPTS];
  logic [NPTS-1:0] pt_use;
  logic [2:0] status, irq_en;
  logic filt_ok, oor, go, tick, lost_ev;
  logic [31:0] step_cnt;
  logic [15:0] cyc_cnt;
  aisc_state_t state;
  logic [4:0] idx;
  logic [1:0] found_cnt;
  logic found;
  logic signed [31:0] x0, y0, x1, y1;
  logic [63:0] num, quo;
  logic [32:0] rem;
  logic [31:0] den;
  logic neg;
  logic [6:0] div_cnt;
  logic signed [31:0] raw_out;
  logic wr, rd_setup, pt_hit, mapped;
  logic [4:0] pt_idx;
  logic [31:0] rdata;
  logic signed [31:0] next_filt, next_in;
  logic [4:0] sh;

  assign wr = psel && penable && pwrite;
  assign rd_setup = psel && !penable;
  assign pt_hit = (paddr >= OFS_PT_BASE) && (paddr < OFS_PT_END);
  assign pt_idx = 5'((paddr - OFS_PT_BASE) >> 3);
  assign pready = psel && penable;
  assign pslverr = pready && !mapped;

  always_comb begin
    rdata = 32'h0000_0000;
    mapped = 1'b1;
    case (paddr)
      OFS_CTRL: rdata = {26'h0, rnd_mode, 1'b0, oor_en, filt_en, ctrl_en};
      OFS_SRC: rdata = {26'h0, src_sel};
      OFS_CYCLE: rdata = {16'h0, cycle_steps};
      OFS_TC: rdata = {16'h0, tc_steps};
      OFS_MIN: rdata = in_min;
      OFS_MAX: rdata = in_max;
      OFS_INPUT: rdata = cur_in;
      OFS_OUTPUT: rdata = curve_value;
      OFS_STATUS: rdata = {29'h0, status};
      OFS_CLEAR: rdata = 32'h0000_0000;
      OFS_IRQ_EN: rdata = {29'h0, irq_en};
      OFS_PT_USE: rdata = {12'h0, pt_use};
      default: begin
        if (pt_hit) begin
          rdata = paddr[2] ? pt_y[pt_idx] : pt_x[pt_idx];
        end else begin
          mapped = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup && !pwrite) begin
      prdata <= rdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_en <= 1'b0;
      filt_en <= 1'b0;
      oor_en <= 1'b0;
      rnd_mode <= RND_FLOAT;
      src_sel <= 6'h00;
      cycle_steps <= CYCLE_RST; // see (R6)
      tc_steps <= TC_RST;
      in_min <= 32'h0000_0000;
      in_max <= 32'h0000_0000;
      irq_en <= 3'h0;
      pt_use <= 20'h0_0003; // see (R8)
      for (int i = 0; i < NPTS; i++) begin
        pt_x[i] <= (i == 1) ? PT2_X_RST : 32'h0000_0000;
        pt_y[i] <= 32'h0000_0000;
      end
    end else if (wr) begin
      case (paddr)
        OFS_CTRL: begin
          ctrl_en <= pwdata[CTRL_EN];
          filt_en <= pwdata[CTRL_FILT];
          oor_en <= pwdata[CTRL_OOR];
          rnd_mode <= pwdata[CTRL_RND +: 2];
        end
        // codes above the last source are clamped
        OFS_SRC: src_sel <= (pwdata[5:0] > SRC_MAX) ? SRC_MAX : pwdata[5:0]; // see (R11)
        OFS_CYCLE: cycle_steps <= pwdata[15:0];
        OFS_TC: tc_steps <= pwdata[15:0];
        OFS_MIN: in_min <= pwdata;
        OFS_MAX: in_max <= pwdata;
        OFS_IRQ_EN: irq_en <= pwdata[2:0];
        // the first two points always form the base line
        OFS_PT_USE: pt_use <= pwdata[NPTS-1:0] | 20'h0_0003; // see (R9)
        default: begin
          if (pt_hit && paddr[2]) begin
            pt_y[pt_idx] <= pwdata;
          end else if (pt_hit) begin
            pt_x[pt_idx] <= pwdata;
          end
        end
      endcase
    end
  end

  assign meas_sel = src_sel; // see (R11)

  // update cycle timer; a zero setting behaves as one step
  assign tick = (step_cnt == 32'(STEP_CYCLES - 1)) &&
                ((cyc_cnt + 16'h0001) >= cycle_steps);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_cnt <= 32'h0000_0000;
      cyc_cnt <= 16'h0000;
    end else if (tick || !ctrl_en) begin
      step_cnt <= 32'h0000_0000;
      cyc_cnt <= 16'h0000;
    end else if (step_cnt == 32'(STEP_CYCLES - 1)) begin // see (R6)
      step_cnt <= 32'h0000_0000;
      cyc_cnt <= cyc_cnt + 16'h0001;
    end else begin
      step_cnt <= step_cnt + 32'h0000_0001;
    end
  end

  // a tick during a busy pass is skipped rather than queued
  assign go = tick && ctrl_en && (state == ST_IDLE);

  // coefficient 2^-sh approximates T/(tau+T)
  always_comb begin
    sh = 5'h00;
    for (int s = 0; s < 16; s++) begin
      if (({16'h0000, cycle_steps} << s) < ({16'h0000, cycle_steps} + {16'h0000, tc_steps})) begin
        sh = 5'(s + 1);
      end
    end
  end
  assign next_filt = filt_ok ? (filt + ((meas_value - filt) >>> sh)) : meas_value; // see (R13)
  assign next_in = filt_en ? next_filt : meas_value; // see (R1)
  assign lost_ev = go && !meas_valid;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filt <= 32'h0000_0000;
      filt_ok <= 1'b0;
      cur_in <= 32'h0000_0000;
    end else if (go && meas_valid) begin // see (R5)
      filt <= next_filt; // see (R13)
      filt_ok <= 1'b1;
      cur_in <= next_in; // see (R1)
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oor <= 1'b0;
    end else begin
      oor <= oor_en && ctrl_en && ((cur_in < in_min) || (cur_in > in_max)); // see (R3) (R10)
    end
  end
  assign curve_out_of_range_flag = oor; // see (R4)

  // scan keeps the last two active points, stopping past the input
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      idx <= 5'h00;
      found <= 1'b0;
      found_cnt <= 2'h0;
      x0 <= 32'h0000_0000;
      y0 <= 32'h0000_0000;
      x1 <= 32'h0000_0000;
      y1 <= 32'h0000_0000;
      num <= 64'h0000_0000_0000_0000;
      quo <= 64'h0000_0000_0000_0000;
      rem <= 33'h0_0000_0000;
      den <= 32'h0000_0000;
      neg <= 1'b0;
      div_cnt <= 7'h00;
    end else begin
      case (state)
        ST_IDLE: begin
          if (go) begin
            state <= ST_SCAN;
            idx <= 5'h00;
            found <= 1'b0;
            found_cnt <= 2'h0;
          end
        end
        ST_SCAN: begin
          if (pt_use[idx] && !found) begin // see (R9)
            x0 <= x1;
            y0 <= y1;
            x1 <= pt_x[idx];
            y1 <= pt_y[idx];
            if (found_cnt != 2'h0 && pt_x[idx] > cur_in) begin // see (R12)
              found <= 1'b1;
            end
            if (found_cnt != 2'h2) begin
              found_cnt <= found_cnt + 2'h1;
            end
          end
          if (idx == 5'(NPTS - 1)) begin
            state <= ST_DIV;
            div_cnt <= 7'h00;
          end else begin
            idx <= idx + 5'h01;
          end
        end
        ST_DIV: begin
          if (div_cnt == 7'h00) begin
            begin : setup
              logic signed [32:0] dx, dy, dd;
              logic signed [65:0] p;
              dx = 33'(cur_in) - 33'(x0);
              dy = 33'(y1) - 33'(y0);
              dd = 33'(x1) - 33'(x0);
              p = 66'(dx) * 66'(dy);
              num <= p[65] ? 64'(-p) : p[63:0];
              den <= dd[32] ? 32'(-dd) : dd[31:0];
              neg <= p[65] ^ dd[32];
              rem <= 33'h0_0000_0000;
              quo <= 64'h0000_0000_0000_0000;
            end
            div_cnt <= 7'h01;
          end else begin
            begin : step
              logic [32:0] r;
              r = {rem[31:0], num[63]};
              num <= {num[62:0], 1'b0};
              if (r >= {1'b0, den}) begin
                rem <= r - {1'b0, den};
                quo <= {quo[62:0], 1'b1};
              end else begin
                rem <= r;
                quo <= {quo[62:0], 1'b0};
              end
            end
            if (div_cnt == 7'(DIV_STEPS)) begin
              state <= ST_OUT;
            end else begin
              div_cnt <= div_cnt + 7'h01;
            end
          end
        end
        ST_OUT: state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
    end
  end

  // coincident points give the lower point's output instead of dividing by zero
  assign raw_out = (den == 32'h0000_0000) ? y0 :
                   (neg ? (y0 - quo[31:0]) : (y0 + quo[31:0])); // see (R12)

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      curve_value <= 32'h0000_0000;
      curve_value_valid <= 1'b0;
    end else begin
      curve_value_valid <= (state == ST_OUT);
      if (state == ST_OUT) begin
        case (rnd_mode) // see (R7)
          RND_FLOOR: curve_value <= raw_out & ~FRAC_MASK;
          RND_CEIL: curve_value <= (raw_out + FRAC_MASK) & ~FRAC_MASK;
          RND_NEAR: curve_value <= (raw_out + FRAC_HALF) & ~FRAC_MASK;
          default: curve_value <= raw_out;
        endcase
      end
    end
  end

  // sticky events: a set in the clearing cycle survives
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= 3'h0;
    end else begin
      status <= (status & ~((wr && paddr == OFS_CLEAR) ? pwdata[2:0] : 3'h0)) |
                {(state == ST_OUT), lost_ev, (oor_en && ctrl_en && !oor &&
                 ((cur_in < in_min) || (cur_in > in_max)))}; // see (R4)
    end
  end
  assign irq = |(status & irq_en);

  sequence s_scan;
    (state == ST_SCAN) ##20 (state == ST_DIV);
  endsequence

  a_oor_gated: assert property (@(posedge pclk) disable iff (!presetn) // see (R10)
    !oor_en |=> !curve_out_of_range_flag) else $error("flag high with signalling off");
  a_oor_limit: assert property (@(posedge pclk) disable iff (!presetn) // see (R3)
    (oor_en && ctrl_en && (cur_in > in_max || cur_in < in_min)) |=> curve_out_of_range_flag)
    else $error("limit violation not flagged");
  a_oor_event: assert property (@(posedge pclk) disable iff (!presetn) // see (R4)
    $rose(curve_out_of_range_flag) |-> status[EV_OOR]) else $error("flag rise not recorded");
  a_lost_hold: assert property (@(posedge pclk) disable iff (!presetn) // see (R5)
    (go && !meas_valid) |=> $stable(cur_in)) else $error("input moved on lost signal");
  a_tick_restart: assert property (@(posedge pclk) disable iff (!presetn) // see (R6)
    tick |=> (step_cnt == 32'h0000_0000 && cyc_cnt == 16'h0000)) else $error("cycle timer slip");
  a_raw_pass: assert property (@(posedge pclk) disable iff (!presetn) // see (R1)
    (go && meas_valid && !filt_en) |=> cur_in == $past(meas_value)) else $error("raw not taken");
  a_filt_steady: assert property (@(posedge pclk) disable iff (!presetn) // see (R13)
    (go && meas_valid && filt_en && filt_ok && meas_value == filt) |=> cur_in == $past(filt))
    else $error("filter moved on steady input");
  a_scan_len: assert property (@(posedge pclk) disable iff (!presetn) // see (R9)
    go |=> s_scan) else $error("scan length wrong");
  a_div_bound: assert property (@(posedge pclk) disable iff (!presetn) // see (R12)
    $rose(state == ST_DIV) |-> ##[65:66] (state == ST_OUT)) else $error("divide overran");
  a_round_int: assert property (@(posedge pclk) disable iff (!presetn) // see (R7)
    (curve_value_valid && $past(rnd_mode) != RND_FLOAT) |->
    (curve_value & FRAC_MASK) == 32'h0000_0000)
    else $error("rounded output has fraction");
endmodule : aisc_curve
`default_nettype wire

// [aisc_fe_model.sv]
// Purpose: behavioural measurement front end feeding the scaling curve
// Assumes: answers meas_sel in the same cycle with a Q24.8 value
// Notes: the bench steers the base value and a lost-signal switch
`timescale 1ns/1ps
`default_nettype none
module aisc_fe_model (
  input wire logic pclk,
  input wire logic [5:0] meas_sel,
  input wire logic lost,
  input wire logic signed [31:0] base,
  output logic signed [31:0] meas_value,
  output logic meas_valid
);
  logic signed [31:0] last_good = 32'sh0000_0000;
  always_ff @(posedge pclk) begin
    if (!lost) begin
      last_good <= meas_value;
    end
  end
  // each source gives base plus its code in whole units
  // a dead line shows the inverse, so a held value cannot pass by luck
  assign meas_value = lost ? ~last_good : base + {18'h0_0000, meas_sel, 8'h00};
  assign meas_valid = !lost;
endmodule : aisc_fe_model
`default_nettype wire

// [tb_analog_input_scaling_curve.sv]
// Purpose: self-checking bench for the analog input scaling curve
// Assumes: STEP_CYCLES of 10, so one update every CYCLE*10 clocks
// Notes: results are taken on the edge that sees the valid pulse
`timescale 1ns/1ps
`default_nettype none
module tb_analog_input_scaling_curve;
  import aisc_pkg::*;
  localparam int STEPS = 10;
  typedef struct {
    logic [31:0] src;
    logic [31:0] base;
    logic [31:0] ctrl;
    logic [31:0] lo;
    logic [31:0] hi;
    logic [31:0] exp_out;
    logic exp_flag;
  } aisc_row_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [5:0] meas_sel;
  logic signed [31:0] meas_value;
  logic meas_valid;
  logic signed [31:0] curve_value;
  logic curve_value_valid;
  logic curve_out_of_range_flag;
  logic irq;
  logic lost = 1'b0;
  logic signed [31:0] base = 32'sh0000_0000;
  int error_cnt = 0;
  int cmp_count = 0;
  int n;
  logic [31:0] rd;
  logic err;
  // line through (0,0) and (16,32): output is twice the input
  aisc_row_t rows [8] = '{
    '{32'h0000_0000, 32'h0000_0140, 32'h0000_0005, 32'h0000_0000, 32'h0000_1000, 32'h0000_0280, 1'b0},
    '{32'h0000_0000, 32'h0000_0120, 32'h0000_0015, 32'h0000_0000, 32'h0000_1000, 32'h0000_0200, 1'b0},
    '{32'h0000_0000, 32'h0000_0120, 32'h0000_0025, 32'h0000_0000, 32'h0000_1000, 32'h0000_0300, 1'b0},
    '{32'h0000_0000, 32'h0000_0120, 32'h0000_0035, 32'h0000_0000, 32'h0000_1000, 32'h0000_0200, 1'b0},
    '{32'h0000_0000, 32'h0000_0140, 32'h0000_0035, 32'h0000_0000, 32'h0000_1000, 32'h0000_0300, 1'b0},
    '{32'h0000_0029, 32'h0000_0020, 32'h0000_0005, 32'h0000_0000, 32'h0000_1000, 32'h0000_5240, 1'b1},
    '{32'h0000_0032, 32'h0000_0020, 32'h0000_0001, 32'h0000_0000, 32'h0000_1000, 32'h0000_5240, 1'b0},
    '{32'h0000_0000, 32'h0000_0020, 32'h0000_0005, 32'h0000_0040, 32'h0000_1000, 32'h0000_0040, 1'b1}
  };
  aisc_curve #(.STEP_CYCLES(STEPS)) u_aisc_curve (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .meas_sel(meas_sel), .meas_value(meas_value), .meas_valid(meas_valid),
    .curve_value(curve_value), .curve_value_valid(curve_value_valid),
    .curve_out_of_range_flag(curve_out_of_range_flag), .irq(irq)
  );
  aisc_fe_model u_aisc_fe_model (
    .pclk(pclk), .meas_sel(meas_sel), .lost(lost), .base(base),
    .meas_value(meas_value), .meas_valid(meas_valid)
  );
  always #50 pclk = ~pclk;
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t value %h expected %h", $time, got, exp);
    end
  endtask : chk32
  task automatic chk1(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t bit %b expected %b", $time, got, exp);
    end
  endtask : chk1
  // entered just after a rising edge; holds the request until pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wait_result();
    n = 0;
    @(posedge pclk);
    while (curve_value_valid !== 1'b1 && n < 400) begin
      n++;
      @(posedge pclk);
    end
    if (n >= 400) chk1(1'b0, 1'b1);
  endtask : wait_result
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test
  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    finish_test();
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk32(curve_value, 32'h0000_0000);
    apb(1'b0, OFS_CYCLE, 32'h0000_0000);
    chk32(rd, 32'h0000_001E);
    apb(1'b0, OFS_CTRL, 32'h0000_0000);
    chk32(rd, 32'h0000_0000);
    apb(1'b0, 12'h048, 32'h0000_0000);
    chk32(rd, 32'h0000_0100);
    apb(1'b0, OFS_PT_USE, 32'h0000_0000);
    chk32(rd, 32'h0000_0003);
    apb(1'b0, 12'h0F0, 32'h0000_0000);
    chk1(err, 1'b1);
    chk32(rd, 32'h0000_0000);
    apb(1'b1, OFS_CYCLE, 32'h0000_000A);
    apb(1'b1, 12'h048, 32'h0000_1000);
    apb(1'b1, 12'h04C, 32'h0000_2000);
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, OFS_SRC, rows[i].src);
      apb(1'b1, OFS_MIN, rows[i].lo);
      apb(1'b1, OFS_MAX, rows[i].hi);
      base <= rows[i].base;
      apb(1'b1, OFS_CTRL, rows[i].ctrl);
      wait_result();
      wait_result();
      chk32(curve_value, rows[i].exp_out);
      chk1(curve_out_of_range_flag, rows[i].exp_flag);
    end
    // mid-run reset: filter history must restart from the next raw sample
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk32(curve_value, 32'h0000_0000);
    chk1(curve_out_of_range_flag, 1'b0);
    apb(1'b1, OFS_CYCLE, 32'h0000_000A);
    apb(1'b1, 12'h048, 32'h0000_1000);
    apb(1'b1, 12'h04C, 32'h0000_2000);
    // default time constant of 200 steps is over twice any test disturbance
    apb(1'b1, OFS_SRC, 32'h0000_0000);
    base <= 32'sh0000_0100;
    apb(1'b1, OFS_CTRL, 32'h0000_0003);
    wait_result();
    wait_result();
    base <= 32'sh0000_2100;
    wait_result();
    apb(1'b0, OFS_INPUT, 32'h0000_0000);
    chk32(rd, 32'h0000_0200);
    chk32(curve_value, 32'h0000_0400);
    base <= 32'sh0000_0180;
    apb(1'b1, OFS_CTRL, 32'h0000_0001);
    apb(1'b1, OFS_IRQ_EN, 32'h0000_0002);
    wait_result();
    apb(1'b1, OFS_CLEAR, 32'h0000_0007);
    wait_result();
    chk1(irq, 1'b0);
    lost <= 1'b1;
    // a pass while lost still gives a result from the held input; wait one whole update cycle for the lost event
    repeat (10 * STEPS + 10) @(posedge pclk);
    apb(1'b0, OFS_INPUT, 32'h0000_0000);
    chk32(rd, 32'h0000_0180);
    chk1(irq, 1'b1);
    apb(1'b1, OFS_IRQ_EN, 32'h0000_0000);
    chk1(irq, 1'b0);
    lost <= 1'b0;
    wait_result();
    apb(1'b1, OFS_CLEAR, 32'h0000_0007);
    apb(1'b1, OFS_IRQ_EN, 32'h0000_0002);
    chk1(irq, 1'b0);
    apb(1'b0, OFS_STATUS, 32'h0000_0000);
    chk1(rd[EV_LOST], 1'b0);
    // third and last used points flatten the top: a bare line would give 0x3000
    apb(1'b1, 12'h050, 32'h0000_2000);
    apb(1'b1, 12'h054, 32'h0000_2000);
    apb(1'b1, 12'h0D8, 32'h0000_3000);
    apb(1'b1, 12'h0DC, 32'h0000_2000);
    apb(1'b1, OFS_PT_USE, 32'h0008_0007);
    base <= 32'sh0000_1800;
    wait_result();
    wait_result();
    chk32(curve_value, 32'h0000_2000);
    base <= 32'sh0000_2800;
    wait_result();
    chk32(curve_value, 32'h0000_2000);
    apb(1'b1, OFS_CYCLE, 32'h0000_000C);
    wait_result();
    wait_result();
    wait_result();
    chk32(n, 12 * STEPS - 1);
    finish_test();
  end
endmodule : tb_analog_input_scaling_curve
`default_nettype wire
